/* File: hdl/lpm_consts.vh */
// lpm_consts.vh: constants for the low power mode controller
// assumes inclusion by bare name from hdl/
`ifndef LPM_CONSTS_VH
`define LPM_CONSTS_VH
// register indices (byte address = index * 4)
`define LPM_REG_MODE_CTRL 4'h0
`define LPM_REG_STOP_CTRL 4'h1
`define LPM_REG_STATUS 4'h2
`define LPM_REG_WAKE_STATUS 4'h3
`define LPM_REG_IO_LATCH 4'h4
// run mode select encodings
`define LPM_RUN_MODE_SELECT_RUN 2'h0
`define LPM_RUN_MODE_SELECT_VERY_LOW_POWER_RUN 2'h2
`define LPM_RUN_MODE_SELECT_HIGH_SPEED_RUN 2'h3
// stop mode select encodings
`define LPM_STOPM_NORMAL 3'h0
`define LPM_STOPM_VERY_LOW_POWER_STOP 3'h2
`define LPM_STOPM_LLS 3'h3
`define LPM_STOPM_VLLS 3'h4
// low leakage sub-modes
`define LPM_SUB_PARTIAL 2'h2
`define LPM_SUB_FULL 2'h3
// clock generator modes
`define LPM_CG_FEI 3'h0
`define LPM_CG_PEE 3'h4
`define LPM_CG_PBE 3'h5
// reset source status bits
`define LPM_SRS_WAKEUP 0
`define LPM_SRS_NMI_WAKE 1
// power modes
`define LPM_M_RUN 4'h0
`define LPM_M_VERY_LOW_POWER_RUN 4'h1
`define LPM_M_WAIT 4'h2
`define LPM_M_VERY_LOW_POWER_WAIT 4'h3
`define LPM_M_STOP 4'h4
`define LPM_M_VERY_LOW_POWER_STOP 4'h5
`define LPM_M_LLS 4'h6
`define LPM_M_VLLS 4'h7
`define LPM_M_HIGH_SPEED_RUN 4'h8
`endif

/* File: hdl/lpm_controller.v */
// lpm_controller.v: system power mode sequencer with register port
// assumes core sleep/deepsleep/wake inputs on clk; pin-class wake inputs asynchronous
//
// The implementer's own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "lpm_consts.vh"

module lpm_controller (
   input wire clk,
   input wire arst_n,
   input wire [3:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [31:0] reg_rdata,
   input wire boot_low_power,
   input wire sleep_req,
   input wire deep_sleep_req,
   input wire irq_pending,
   input wire debug_active,
   input wire wake_unit_event,
   input wire nmi_wake,
   input wire ext_32k_present,
   input wire [2:0] cg_mode_in,
   input wire flash_prog_req,
   input wire cg_change_req,
   output reg [3:0] power_mode,
   output wire core_clk_en,
   output wire sys_clk_en,
   output wire periph_clk_en,
   output wire intc_en,
   output wire wake_ctrl_en,
   output wire lvd_en,
   output wire loop_en,
   output wire loop_out_en,
   output wire irc_en,
   output wire ext_ref_en,
   output wire lpo_en,
   output wire rtc_en,
   output wire sram_full_ret,
   output wire sram_part_ret,
   output wire io_hold,
   output reg [2:0] cg_mode_restore,
   output reg cg_restore_stb,
   output reg reset_flow_req,
   output reg resume_after_entry,
   output wire flash_prog_grant,
   output wire cg_change_grant
);
   reg [3:0] mode_r;
   reg [1:0] run_sel_r;
   reg [2:0] stop_sel_r;
   reg [1:0] sub_sel_r;
   reg loop_keep_r;
   reg irc_keep_r;
   reg ext_keep_r;
   reg por_keep_r;
   reg very_low_power_run_irq_exit_r;
   reg [2:0] cg_saved_r;
   reg [1:0] srs_r;
   reg io_latch_r;
   reg boot_done_r;
   reg wu_s1_r, wu_s2_r;
   reg nmi_s1_r, nmi_s2_r;
   reg rtc_s1_r, rtc_s2_r;
   reg [3:0] mode_nxt;
   wire wr_mode = reg_wr && reg_addr == `LPM_REG_MODE_CTRL;
   wire wr_stop = reg_wr && reg_addr == `LPM_REG_STOP_CTRL;
   wire wr_srs = reg_wr && reg_addr == `LPM_REG_WAKE_STATUS;
   wire wr_iso = reg_wr && reg_addr == `LPM_REG_IO_LATCH && reg_wdata[0];
   wire in_very_low_power_run = mode_r == `LPM_M_VERY_LOW_POWER_RUN;
   wire in_run = mode_r == `LPM_M_RUN;
   wire is_lls = mode_r == `LPM_M_LLS;
   wire is_vlls = mode_r == `LPM_M_VLLS;
   wire stop_cls = mode_r == `LPM_M_STOP || mode_r == `LPM_M_VERY_LOW_POWER_STOP || is_lls || is_vlls;
   wire wait_cls = mode_r == `LPM_M_WAIT || mode_r == `LPM_M_VERY_LOW_POWER_WAIT;
   wire very_low_leakage_stop_zero = is_vlls && sub_sel_r == 2'h0;
   wire very_low_leakage_stop_two = is_vlls && sub_sel_r == `LPM_SUB_PARTIAL;
   // stop target follows the stop select field; very_low_power_run forbids normal stop
   reg [3:0] stop_tgt;
   always @* begin
      case (stop_sel_r)
         `LPM_STOPM_VERY_LOW_POWER_STOP: stop_tgt = `LPM_M_VERY_LOW_POWER_STOP;
         `LPM_STOPM_LLS: stop_tgt = `LPM_M_LLS;
         `LPM_STOPM_VLLS: stop_tgt = `LPM_M_VLLS;
         default: stop_tgt = `LPM_M_STOP;
      endcase
   end

   always @* begin
      mode_nxt = mode_r;
      case (mode_r)
         `LPM_M_RUN: begin
            if (deep_sleep_req) begin
               mode_nxt = stop_tgt;
            end else if (sleep_req) begin
               mode_nxt = `LPM_M_WAIT;
            end else if (wr_mode && reg_wdata[1:0] == `LPM_RUN_MODE_SELECT_VERY_LOW_POWER_RUN) begin
               mode_nxt = `LPM_M_VERY_LOW_POWER_RUN;
            end else if (wr_mode && reg_wdata[1:0] == `LPM_RUN_MODE_SELECT_HIGH_SPEED_RUN) begin
               mode_nxt = `LPM_M_HIGH_SPEED_RUN;
            end
         end
         `LPM_M_VERY_LOW_POWER_RUN: begin
            if (deep_sleep_req) begin
               if (stop_tgt != `LPM_M_STOP) begin
                  mode_nxt = stop_tgt;
               end
            end else if (sleep_req) begin
               mode_nxt = `LPM_M_VERY_LOW_POWER_WAIT;
            end else if (wr_mode && reg_wdata[1:0] == `LPM_RUN_MODE_SELECT_RUN) begin
               mode_nxt = `LPM_M_RUN;
            end else if (very_low_power_run_irq_exit_r && irq_pending) begin
               mode_nxt = `LPM_M_RUN;
            end
         end
         `LPM_M_HIGH_SPEED_RUN: begin
            // sleep requests simply ignored here
            if (wr_mode && reg_wdata[1:0] == `LPM_RUN_MODE_SELECT_RUN) begin
               mode_nxt = `LPM_M_RUN;
            end
         end
         `LPM_M_WAIT: begin
            if (irq_pending) begin
               mode_nxt = `LPM_M_RUN;
            end
         end
         `LPM_M_VERY_LOW_POWER_WAIT: begin
            if (irq_pending) begin
               mode_nxt = `LPM_M_VERY_LOW_POWER_RUN;
            end
         end
         `LPM_M_STOP, `LPM_M_VERY_LOW_POWER_STOP: begin
            if (irq_pending) begin
               mode_nxt = run_sel_r == `LPM_RUN_MODE_SELECT_VERY_LOW_POWER_RUN ? `LPM_M_VERY_LOW_POWER_RUN : `LPM_M_RUN;
            end
         end
         `LPM_M_LLS: begin
            if (wu_s2_r) begin
               mode_nxt = run_sel_r == `LPM_RUN_MODE_SELECT_VERY_LOW_POWER_RUN ? `LPM_M_VERY_LOW_POWER_RUN : `LPM_M_RUN;
            end
         end
         `LPM_M_VLLS: begin
            if (wu_s2_r || nmi_s2_r) begin
               mode_nxt = `LPM_M_RUN;
            end
         end
         default: mode_nxt = `LPM_M_RUN;
      endcase
   end

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mode_r <= `LPM_M_RUN;
         boot_done_r <= 1'b0;
         run_sel_r <= `LPM_RUN_MODE_SELECT_RUN;
         stop_sel_r <= `LPM_STOPM_NORMAL;
         sub_sel_r <= 2'h0;
         loop_keep_r <= 1'b0;
         irc_keep_r <= 1'b0;
         ext_keep_r <= 1'b0;
         por_keep_r <= 1'b0;
         very_low_power_run_irq_exit_r <= 1'b0;
         cg_saved_r <= `LPM_CG_FEI;
         srs_r <= 2'h0;
         io_latch_r <= 1'b0;
         cg_mode_restore <= `LPM_CG_FEI;
         cg_restore_stb <= 1'b0;
         reset_flow_req <= 1'b0;
         resume_after_entry <= 1'b0;
         wu_s1_r <= 1'b0;
         wu_s2_r <= 1'b0;
         nmi_s1_r <= 1'b0;
         nmi_s2_r <= 1'b0;
         rtc_s1_r <= 1'b0;
         rtc_s2_r <= 1'b0;
      end else begin
         wu_s1_r <= wake_unit_event;
         wu_s2_r <= wu_s1_r;
         nmi_s1_r <= nmi_wake;
         nmi_s2_r <= nmi_s1_r;
         rtc_s1_r <= ext_32k_present;
         rtc_s2_r <= rtc_s1_r;
         boot_done_r <= 1'b1;
         cg_restore_stb <= 1'b0;
         reset_flow_req <= 1'b0;
         resume_after_entry <= 1'b0;
         if (!boot_done_r && boot_low_power) begin
            mode_r <= `LPM_M_VERY_LOW_POWER_RUN;
            run_sel_r <= `LPM_RUN_MODE_SELECT_VERY_LOW_POWER_RUN;
         end else begin
            mode_r <= mode_nxt;
            if (mode_nxt == `LPM_M_VERY_LOW_POWER_RUN || mode_nxt == `LPM_M_RUN || mode_nxt == `LPM_M_HIGH_SPEED_RUN) begin
               // a reset-flow exit comes back in plain run, so the select follows it
               if (mode_nxt != mode_r && (!wait_cls && !stop_cls || is_vlls)) begin
                  run_sel_r <= mode_nxt == `LPM_M_VERY_LOW_POWER_RUN ? `LPM_RUN_MODE_SELECT_VERY_LOW_POWER_RUN :
                               mode_nxt == `LPM_M_HIGH_SPEED_RUN ? `LPM_RUN_MODE_SELECT_HIGH_SPEED_RUN : `LPM_RUN_MODE_SELECT_RUN;
               end
            end
         end
         if (wr_mode) begin
            very_low_power_run_irq_exit_r <= reg_wdata[4];
         end
         // clock generator mode is sampled on every exit from run, very_low_power_run or high_speed_run, and frozen while wait or stop is active
         if ((in_run || in_very_low_power_run || mode_r == `LPM_M_HIGH_SPEED_RUN) && mode_nxt != mode_r) begin
            cg_saved_r <= cg_mode_in;
         end
         if ((wait_cls || stop_cls) && mode_nxt != mode_r) begin
            if (is_vlls) begin
               cg_mode_restore <= `LPM_CG_FEI;
               reset_flow_req <= ~(very_low_leakage_stop_two && nmi_s2_r);
               io_latch_r <= 1'b1;
            end else if (stop_cls && cg_saved_r == `LPM_CG_PEE && !loop_keep_r) begin
               cg_mode_restore <= `LPM_CG_PBE;
            end else begin
               cg_mode_restore <= cg_saved_r;
            end
            cg_restore_stb <= 1'b1;
            resume_after_entry <= is_lls;
         end
         // wake sets win over a same-cycle software clear
         srs_r <= (wr_srs ? srs_r & ~reg_wdata[1:0] : srs_r) |
                  {((is_vlls && very_low_leakage_stop_two) || is_vlls) && nmi_s2_r && very_low_leakage_stop_two,
                   (is_lls && wu_s2_r) || (is_vlls && (wu_s2_r || nmi_s2_r))};
         if (wr_iso && !(is_vlls && mode_nxt != mode_r)) begin
            io_latch_r <= 1'b0;
         end
         if (wr_stop && (in_run || in_very_low_power_run)) begin
            stop_sel_r <= reg_wdata[2:0];
            sub_sel_r <= reg_wdata[5:4];
            loop_keep_r <= reg_wdata[8];
            irc_keep_r <= reg_wdata[9];
            ext_keep_r <= reg_wdata[10];
            por_keep_r <= reg_wdata[11];
         end
      end
   end

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         power_mode <= `LPM_M_RUN;
      end else begin
         power_mode <= mode_r;
      end
   end

   // debug keeps system clocks alive, costing current in stop
   wire gate_dbg = (mode_r == `LPM_M_STOP || mode_r == `LPM_M_VERY_LOW_POWER_STOP) && debug_active;
   assign core_clk_en = !(wait_cls || stop_cls);
   assign periph_clk_en = !stop_cls || gate_dbg;
   assign sys_clk_en = !stop_cls || gate_dbg;
   assign intc_en = !stop_cls;
   assign wake_ctrl_en = mode_r == `LPM_M_STOP || mode_r == `LPM_M_VERY_LOW_POWER_STOP;
   assign lvd_en = mode_r != `LPM_M_VERY_LOW_POWER_STOP && !is_lls && !is_vlls;
   assign loop_en = !stop_cls && !wait_cls ? 1'b1 : mode_r == `LPM_M_STOP ? loop_keep_r : mode_r == `LPM_M_WAIT;
   assign loop_out_en = !stop_cls;
   assign irc_en = !stop_cls || ((mode_r == `LPM_M_STOP || mode_r == `LPM_M_VERY_LOW_POWER_STOP) && irc_keep_r);
   assign ext_ref_en = !stop_cls && mode_r != `LPM_M_VERY_LOW_POWER_WAIT ? 1'b1 :
                       very_low_leakage_stop_zero ? 1'b0 : ext_keep_r;
   assign lpo_en = !very_low_leakage_stop_zero || por_keep_r;
   assign rtc_en = !very_low_leakage_stop_zero || rtc_s2_r;
   assign sram_full_ret = !is_vlls && !(is_lls && sub_sel_r == `LPM_SUB_PARTIAL) ||
                          (is_vlls && sub_sel_r == `LPM_SUB_FULL);
   assign sram_part_ret = (is_lls && sub_sel_r == `LPM_SUB_PARTIAL) || very_low_leakage_stop_two;
   assign io_hold = stop_cls || io_latch_r;
   assign flash_prog_grant = flash_prog_req && in_run;
   assign cg_change_grant = cg_change_req && !in_very_low_power_run && !wait_cls && !stop_cls;
   // interrupt priority after reset belongs to the interrupt controller
   // clock limits are software's to keep

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata <= 32'h0;
      end else if (reg_rd) begin
         case (reg_addr)
            `LPM_REG_MODE_CTRL: reg_rdata <= {27'h0, very_low_power_run_irq_exit_r, 2'h0, run_sel_r};
            `LPM_REG_STOP_CTRL: reg_rdata <= {20'h0, por_keep_r, ext_keep_r, irc_keep_r, loop_keep_r,
                                              2'h0, sub_sel_r, 1'b0, stop_sel_r};
            `LPM_REG_STATUS: reg_rdata <= {25'h0, cg_saved_r, mode_r};
            `LPM_REG_WAKE_STATUS: reg_rdata <= {30'h0, srs_r};
            `LPM_REG_IO_LATCH: reg_rdata <= {31'h0, io_latch_r};
            default: reg_rdata <= 32'h0;
         endcase
      end else begin
         reg_rdata <= 32'h0;
      end
   end
endmodule
`default_nettype wire

/* File: verification/lpm_controller_checker.sv */
// lpm_controller_checker.sv: concurrent checks on the mode sequencer outputs
// assumes power_mode lags the internal mode one edge, enables follow the internal mode
`timescale 1ns/1ps
`default_nettype none
`include "lpm_consts.vh"
module lpm_controller_checker (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [3:0] power_mode,
   input wire logic debug_active,
   input wire logic core_clk_en,
   input wire logic sys_clk_en,
   input wire logic periph_clk_en,
   input wire logic intc_en,
   input wire logic wake_ctrl_en,
   input wire logic lvd_en,
   input wire logic loop_en,
   input wire logic irc_en,
   input wire logic flash_prog_grant,
   input wire logic cg_change_grant
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   // enables run one edge ahead of power_mode, hence $past on them
   wait_gate_a: assert property (
      power_mode == `LPM_M_WAIT |-> !$past(core_clk_en) && $past(periph_clk_en) && $past(intc_en))
      else $error("wait gating wrong");
   stop_gate_a: assert property (
      power_mode inside {`LPM_M_STOP, `LPM_M_VERY_LOW_POWER_STOP} && !$past(debug_active)
      |-> !$past(sys_clk_en) && !$past(periph_clk_en) && !$past(intc_en) && $past(wake_ctrl_en))
      else $error("stop gating wrong");
   stop_lvd_a: assert property (
      power_mode == `LPM_M_STOP |-> $past(lvd_en))
      else $error("lvd off in stop");
   lls_static_a: assert property (
      power_mode == `LPM_M_LLS |-> !$past(loop_en) && !$past(irc_en) && !$past(sys_clk_en))
      else $error("clock alive in lls");
   very_low_power_run_refuse_a: assert property (
      power_mode == `LPM_M_VERY_LOW_POWER_RUN |-> !$past(flash_prog_grant) && !$past(cg_change_grant))
      else $error("grant in very_low_power_run");
   high_speed_run_exit_a: assert property (
      $past(power_mode) == `LPM_M_HIGH_SPEED_RUN |-> power_mode inside {`LPM_M_HIGH_SPEED_RUN, `LPM_M_RUN})
      else $error("low power from high_speed_run");
   very_low_power_wait_entry_a: assert property (
      $changed(power_mode) && power_mode == `LPM_M_VERY_LOW_POWER_WAIT |-> $past(power_mode) == `LPM_M_VERY_LOW_POWER_RUN)
      else $error("bad very_low_power_wait entry");
   run_entry_a: assert property (
      $changed(power_mode) && power_mode inside {`LPM_M_WAIT, `LPM_M_STOP} |-> $past(power_mode) == `LPM_M_RUN)
      else $error("bad wait or stop entry");
endmodule
bind lpm_controller lpm_controller_checker i_lpm_controller_checker (.clk(clk), .arst_n(arst_n),
   .power_mode(power_mode), .debug_active(debug_active), .core_clk_en(core_clk_en), .sys_clk_en(sys_clk_en),
   .periph_clk_en(periph_clk_en), .intc_en(intc_en), .wake_ctrl_en(wake_ctrl_en), .lvd_en(lvd_en),
   .loop_en(loop_en), .irc_en(irc_en), .flash_prog_grant(flash_prog_grant), .cg_change_grant(cg_change_grant));
`default_nettype wire

/* File: verification/lpm_core_model.sv */
// lpm_core_model.sv: core stand-in issuing sleep and deep sleep requests
// assumes one command at a time; lag sets how slowly the core reacts
`timescale 1ns/1ps
`default_nettype none
module lpm_core_model (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [1:0] cmd,
   input wire logic [3:0] lag,
   output var logic sleep_req,
   output var logic deep_sleep_req
);
   logic [3:0] cnt_r;
   logic [1:0] kind_r;
   // one pulse per command; bit 1 deep sleep, bit 0 ordinary sleep
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_r <= 4'h0;
         kind_r <= 2'h0;
         sleep_req <= 1'b0;
         deep_sleep_req <= 1'b0;
      end else begin
         sleep_req <= kind_r[0] && cnt_r == 4'h0;
         deep_sleep_req <= kind_r[1] && cnt_r == 4'h0;
         cnt_r <= cmd != 2'h0 ? lag : cnt_r - {3'h0, cnt_r != 4'h0};
         kind_r <= cmd != 2'h0 ? cmd : (cnt_r == 4'h0 ? 2'h0 : kind_r);
      end
   end
endmodule
`default_nettype wire

/* File: verification/tb_lpm_controller.sv */
// tb_lpm_controller.sv: self-checking bench with its own mode model
// assumes the core model and the bound checker are compiled with it
`timescale 1ns/1ps
`default_nettype none
`include "lpm_consts.vh"
module tb_lpm_controller;
   logic clk = 0, arst_n = 0, wr_s = 0, rd_s = 0, irq = 0, wu = 0, fp = 0, nm = 0, bt = 0;
   logic [3:0] addr = 4'h0, lag = 4'h0;
   logic [1:0] cmd = 2'h0;
   logic [2:0] cg = 3'h0;
   logic [31:0] wd = 32'h0, seed = 32'h18FD666A;
   wire logic [31:0] rdat;
   wire logic [3:0] pm;
   wire logic [2:0] cgr;
   wire logic slp, dsl, cen, full, lpo, ext, hold, rfl, res, fg, cgg, rtc, part, stb;
   int miscompares = 0, check_count = 0, cyc = 0, xm = 0, rs = 0, ss = 0, nrf = 0, nres = 0, nstb = 0;
   initial forever #5 clk = ~clk;
   lpm_core_model i_lpm_core_model (.clk(clk), .arst_n(arst_n), .cmd(cmd), .lag(lag), .sleep_req(slp),
      .deep_sleep_req(dsl));
   lpm_controller i_lpm_controller (.clk(clk), .arst_n(arst_n), .reg_addr(addr), .reg_wdata(wd), .reg_wr(wr_s),
      .reg_rd(rd_s), .reg_rdata(rdat), .boot_low_power(bt), .sleep_req(slp), .deep_sleep_req(dsl),
      .irq_pending(irq), .debug_active(1'b0), .wake_unit_event(wu), .nmi_wake(nm), .ext_32k_present(1'b0),
      .cg_mode_in(cg), .flash_prog_req(fp), .cg_change_req(fp), .power_mode(pm), .core_clk_en(cen),
      .sys_clk_en(), .periph_clk_en(), .intc_en(), .wake_ctrl_en(), .lvd_en(), .loop_en(), .loop_out_en(),
      .irc_en(), .ext_ref_en(ext), .lpo_en(lpo), .rtc_en(rtc), .sram_full_ret(full), .sram_part_ret(part),
      .io_hold(hold), .cg_mode_restore(cgr), .cg_restore_stb(stb), .reset_flow_req(rfl),
      .resume_after_entry(res), .flash_prog_grant(fg), .cg_change_grant(cgg));
   task print_verdict;
      if (miscompares == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // pulses are counted here so a missed or doubled one shows up later
   always @(posedge clk) begin
      cyc++;
      nrf += int'(rfl === 1'b1);
      nres += int'(res === 1'b1);
      nstb += int'(stb === 1'b1);
      if (cyc == 4000) begin
         miscompares++;
         print_verdict;
      end
   end
   task chk(input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         miscompares++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   function logic [31:0] lfsr(input logic [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // ev 1 sleep, 2 deep sleep, 3 wake
   function int model(input int m, input int ev);
      if (ev == 1) return m == `LPM_M_RUN ? `LPM_M_WAIT : m == `LPM_M_VERY_LOW_POWER_RUN ? `LPM_M_VERY_LOW_POWER_WAIT : m;
      if (ev == 2 && !(m inside {`LPM_M_RUN, `LPM_M_VERY_LOW_POWER_RUN})) return m;
      if (ev == 2 && ss == `LPM_STOPM_NORMAL) return m == `LPM_M_RUN ? `LPM_M_STOP : m;
      if (ev == 2) return ss == `LPM_STOPM_VERY_LOW_POWER_STOP ? `LPM_M_VERY_LOW_POWER_STOP : ss == `LPM_STOPM_LLS ? `LPM_M_LLS : `LPM_M_VLLS;
      if (m == `LPM_M_VERY_LOW_POWER_WAIT) return `LPM_M_VERY_LOW_POWER_RUN;
      if (m inside {`LPM_M_WAIT, `LPM_M_VLLS}) return `LPM_M_RUN;
      return rs == 2 ? `LPM_M_VERY_LOW_POWER_RUN : `LPM_M_RUN;
   endfunction
   // a refused request is given time to show up wrongly before the check
   task wmode(input int m);
      int n;
      n = 0;
      if (m == xm) repeat (12) @(posedge clk) #1;
      while (pm !== m[3:0] && n < 30) begin
         @(posedge clk) #1;
         n++;
      end
      chk(pm, m);
      xm = m;
   endtask
   task wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      wr_s <= 1'b1;
      addr <= a;
      wd <= d;
      @(posedge clk) #1;
      wr_s <= 1'b0;
      if (a == `LPM_REG_STOP_CTRL) ss = d[2:0];
      if (a == `LPM_REG_MODE_CTRL) rs = d[1:0];
      if (a == `LPM_REG_MODE_CTRL) wmode(rs == 2 ? `LPM_M_VERY_LOW_POWER_RUN : rs == 3 ? `LPM_M_HIGH_SPEED_RUN : `LPM_M_RUN);
   endtask
   task rd(input logic [3:0] a, input logic [31:0] e);
      @(posedge clk);
      rd_s <= 1'b1;
      addr <= a;
      @(posedge clk) #1;
      rd_s <= 1'b0;
      chk(rdat, e);
   endtask
   task go(input int k);
      seed = lfsr(seed);
      @(posedge clk);
      if (k == 3) {irq, wu} <= xm inside {`LPM_M_LLS, `LPM_M_VLLS} ? 2'b01 : 2'b10;
      else cmd <= k[1:0];
      lag <= {1'b0, seed[2:0]};
      @(posedge clk) #1;
      cmd <= 2'h0;
      wmode(model(xm, k));
      {irq, wu} <= 2'b00;
   endtask
   initial begin
      repeat (5) @(posedge clk);
      arst_n <= 1'b1;
      repeat (2) @(posedge clk);
      rd(`LPM_REG_MODE_CTRL, 0);
      rd(4'hF, 0);
      cg <= `LPM_CG_PEE;
      go(1);
      chk(cen, 0);
      cg <= seed[2:0];
      go(3);
      chk(cgr, `LPM_CG_PEE);
      cg <= `LPM_CG_PEE;
      go(2);
      go(3);
      chk(cgr, `LPM_CG_PBE);
      fp <= 1'b1;
      wr(`LPM_REG_MODE_CTRL, `LPM_RUN_MODE_SELECT_VERY_LOW_POWER_RUN);
      chk({fg, cgg}, 0);
      go(2);
      go(1);
      go(3);
      wr(`LPM_REG_STOP_CTRL, `LPM_STOPM_VERY_LOW_POWER_STOP);
      go(2);
      go(3);
      wr(`LPM_REG_MODE_CTRL, `LPM_RUN_MODE_SELECT_RUN);
      chk(fg, 1);
      wr(`LPM_REG_MODE_CTRL, `LPM_RUN_MODE_SELECT_HIGH_SPEED_RUN);
      go(1);
      go(2);
      wr(`LPM_REG_MODE_CTRL, `LPM_RUN_MODE_SELECT_RUN);
      wr(`LPM_REG_STOP_CTRL, 32'h33);
      go(2);
      chk(full, 1);
      go(3);
      chk(nres, 1);
      rd(`LPM_REG_WAKE_STATUS, 1);
      for (int i = 0; i < 4; i++) begin
         wr(`LPM_REG_STOP_CTRL, 32'h4 | (i << 4));
         go(2);
         if (i == 0) chk({lpo, ext}, 0);
         if (i == 0) chk(rtc, 0);
         if (i == 2) chk(part, 1);
         // stop two is woken by nmi as well, so it skips the reset flow
         nm <= (i == 2);
         go(3);
         nm <= 1'b0;
         chk(nrf, i < 2 ? i + 1 : i);
         chk(cgr, `LPM_CG_FEI);
         chk(hold, 1);
         wr(`LPM_REG_IO_LATCH, 1);
         chk(hold, 0);
         rd(`LPM_REG_WAKE_STATUS, i == 2 ? 3 : 1);
         wr(`LPM_REG_WAKE_STATUS, 3);
      end
      chk(nstb, 9);
      // second reset, this time with the low power boot option set
      arst_n <= 1'b0;
      bt <= 1'b1;
      repeat (5) @(posedge clk);
      arst_n <= 1'b1;
      wmode(`LPM_M_VERY_LOW_POWER_RUN);
      rd(`LPM_REG_MODE_CTRL, `LPM_RUN_MODE_SELECT_VERY_LOW_POWER_RUN);
      print_verdict;
   end
endmodule
`default_nettype wire
